// [fpsr_array_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Array engine stand-in: counts work only while allowed to run
module fpsr_array_model #(
  parameter int RUN_CYC = 40
) (
  input  wire logic sys_clk_i,  // System clock
  input  wire logic rst_i,      // Sync reset
  input  wire logic start_i,    // Launch pulse
  input  wire logic op_run_i,   // Controller lets it run
  input  wire logic op_abort_i, // Kill the operation
  output logic      op_done_o   // Finish pulse
);
  logic [15:0] left_r; // Cycles of work left

  // Frozen while suspended, so a resume continues where it stopped
  always_ff @(posedge sys_clk_i)
  begin
    op_done_o <= 1'b0;
    if (rst_i || op_abort_i)
      left_r <= 16'h0000;
    else if (start_i)
      left_r <= RUN_CYC[15:0];
    else if (op_run_i && left_r != 16'h0000)
    begin
      left_r <= left_r - 16'h0001;
      op_done_o <= (left_r == 16'h0001);
    end
  end
endmodule
`default_nettype wire

// [fpsr_cfg.svh]
`ifndef FPSR_CFG_SVH
`define FPSR_CFG_SVH

// Opcodes handled directly by this block
`define FPSR_OP_GANG_LOCK   8'h7E
`define FPSR_OP_GANG_UNLOCK 8'h98
`define FPSR_OP_PROT_SEL    8'h68
`define FPSR_OP_WRITE_ENABLE_CMD        8'h06
`define FPSR_OP_WRITE_DISABLE_CMD        8'h04
`define FPSR_OP_SUSPEND     8'hB0
`define FPSR_OP_RESUME      8'h30
`define FPSR_OP_RST_ARM     8'h66
`define FPSR_OP_RST         8'h99
`define FPSR_OP_NOP         8'h00
`define FPSR_OP_CR2_RD      8'h71
`define FPSR_OP_CR2_WR      8'h72

// Address bits 31:30 selectors of the second configuration space
`define FPSR_CR2_SEL_LOW    2'h0
`define FPSR_CR2_SEL_MID    2'h1
`define FPSR_CR2_SEL_HIGH   2'h2

// Suspend status bit positions in the security byte
`define FPSR_SCUR_PSUSP_BIT 2
`define FPSR_SCUR_ESUSP_BIT 3

// Reset values
`define FPSR_DYN_RESET      1'b1
`define FPSR_WEL_RESET      1'b0

// Suspend latencies in ns, and in 10 ns clock cycles (rounded down)
`define FPSR_CLK_NS         10
`define FPSR_PSL_NS         20000
`define FPSR_ESL_NS         20000
`define FPSR_PSL_CYC        (`FPSR_PSL_NS / `FPSR_CLK_NS)
`define FPSR_ESL_CYC        (`FPSR_ESL_NS / `FPSR_CLK_NS)

`endif

// [fpsr_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fpsr_cfg.svh"

// Behaviour
// [R1] Gang commands need protect-select mode first
// [R2] Gang lock sets, unlock clears dynamic bits
// [R3] Host sends write enable before gang command
// [R4] Gang opcodes 7Eh/98h, opcode only
// [R5] Gang command off byte boundary is rejected
// [R6] Sector writable only if both bits zero
// [R7] Suspended reads blocked in suspended page/sector
// [R8] Security bit 2/3 show program/erase suspend
// [R9] Resume clears the matching suspend flag
// [R10] Entering suspend clears latch, sets flag
// [R11] Host waits suspend latency before late commands
// [R12] Late command set accepted after suspend latency
// [R13] Free command set accepted anytime in suspend
// [R14] Config2 write: 00/10 accepted, 01 refused
// [R15] Resume sets latch and busy, clears flag
// [R16] Resumed operation runs to done or suspend
// [R17] Host waits resume-to-suspend latency
// [R18] Host waits program/erase time after resume
// [R19] Operation finish clears latch and busy
// [R20] No-operation only cancels armed reset
// [R21] Arm then reset restores defaults, aborts operation
// [R22] Any other command cancels armed reset
// [R23] Suspend with no operation is ignored
module fpsr_ctrl
  import fpsr_pkg::*;
#(
  parameter int SECTORS   = 16,        // Sectors with protection bits
  parameter int SW        = 4,         // Sector index width
  parameter int PAGE_LSB  = 8,         // Page boundary bit
  parameter int SECT_LSB  = 12,        // Sector boundary bit
  parameter int LW        = 16,        // Latency counter width
  parameter int PSL_CYC   = `FPSR_PSL_CYC,
  parameter int ESL_CYC   = `FPSR_ESL_CYC
) (
  input  wire logic               sys_clk_i,      // System clock, 100 MHz
  input  wire logic               rst_i,          // Sync reset, active high
  input  wire logic               cmd_valid_i,    // Command ended by chip select
  input  wire logic [7:0]         cmd_opcode_i,   // Command opcode
  input  wire logic [31:0]        cmd_addr_i,     // Command address
  input  wire logic               cmd_aligned_i,  // Select rose on byte boundary
  input  wire logic               op_start_i,     // Program/erase launched
  input  wire logic               op_erase_i,     // Launched op is an erase
  input  wire logic [31:0]        op_addr_i,      // Launched op address
  input  wire logic               op_done_i,      // Array engine finished
  input  wire logic [31:0]        rd_addr_i,      // Array read address
  input  wire logic [SECTORS-1:0] solid_bits_i,   // Solid protect bits
  input  wire logic [SW-1:0]      sector_sel_i,   // Sector to query
  output logic                    cmd_accept_o,   // Command accepted pulse
  output logic                    cmd_reject_o,   // Command refused pulse
  output logic                    wel_o,          // Write enable latch
  output logic                    wip_o,          // Write in progress
  output logic [7:0]              scur_o,         // Security status byte
  output logic                    op_run_o,       // Array engine may run
  output logic                    op_abort_o,     // Abort pulse to engine
  output logic                    soft_rst_o,     // Restore defaults pulse
  output logic                    prot_mode_o,    // Protect-select active
  output logic                    rd_block_o,     // Read address blocked
  output logic                    writable_o,     // Queried sector writable
  output logic [SECTORS-1:0]      dyn_bits_o      // Dynamic protect bits
);

  import fpsr_pkg::*;

  fpsr_state_t state_r;       // Operation engine state
  fpsr_state_t state_nxt;     // Next engine state
  logic        wel_r;         // Write enable latch
  logic        wip_r;         // Write in progress
  logic        psusp_r;       // Program suspended flag
  logic        esusp_r;       // Erase suspended flag
  logic        erase_r;       // Current op is an erase
  logic [31:0] op_addr_r;     // Current op address
  logic        armed_r;       // Reset armed
  logic        prot_mode_r;   // Protect-select executed
  logic        free_cmd;      // Allowed anytime in suspend
  logic        late_cmd;      // Allowed after suspend latency
  logic        ok;            // Command allowed in this state
  logic        go;            // Command taken this cycle
  logic        gang_cmd;      // Opcode is a gang command
  logic        do_reset;      // Software reset fires
  logic        do_lock;       // Gang lock fires
  logic        do_unlock;     // Gang unlock fires
  logic        lat_load;      // Start suspend latency
  logic        lat_done;      // Suspend latency over
  logic [LW-1:0] lat_cnt;     // Latency to load
  logic        prot_wr;       // Protect module writable answer

  // Command classes for the suspended state
  always_comb
  begin
    free_cmd = 1'b0;
    late_cmd = 1'b0;
    unique case (cmd_opcode_i)
      8'h04, 8'h05, 8'h15, 8'h2B, 8'hAB,
      8'h66, 8'h99, 8'h00:
        free_cmd = 1'b1;  // [R13]
      `FPSR_OP_CR2_RD:
      begin
        free_cmd = (cmd_addr_i[31:30] == `FPSR_CR2_SEL_HIGH);  // [R13]
        late_cmd = (cmd_addr_i[31:30] == `FPSR_CR2_SEL_LOW) ||
                   (cmd_addr_i[31:30] == `FPSR_CR2_SEL_MID);   // [R12]
      end
      `FPSR_OP_CR2_WR:
      begin
        // Selector 01 falls in neither class and is refused
        free_cmd = (cmd_addr_i[31:30] == `FPSR_CR2_SEL_HIGH);  // [R14]
        late_cmd = (cmd_addr_i[31:30] == `FPSR_CR2_SEL_LOW);   // [R14]
      end
      8'h03, 8'h13, 8'h0B, 8'h0C, 8'hEC, 8'hEE, 8'h5A,
      8'h9F, 8'hC0, 8'hB1, 8'hC1, 8'h06, 8'h30, 8'h2D,
      8'hE2, 8'h16, 8'hE0:
        late_cmd = 1'b1;  // [R12]
      default:
      begin
        free_cmd = 1'b0;
        late_cmd = 1'b0;
      end
    endcase
  end

  // Acceptance per engine state
  always_comb
  begin
    gang_cmd = (cmd_opcode_i == `FPSR_OP_GANG_LOCK) ||
               (cmd_opcode_i == `FPSR_OP_GANG_UNLOCK);  // [R4]
    unique case (state_r)
      FPSR_IDLE:
        // Suspend and resume mean nothing with no operation
        ok = (cmd_opcode_i != `FPSR_OP_SUSPEND) &&
             (cmd_opcode_i != `FPSR_OP_RESUME);  // [R23]
      FPSR_RUN:
        ok = free_cmd || (cmd_opcode_i == `FPSR_OP_SUSPEND);
      FPSR_SWAIT:
        ok = free_cmd;  // [R13]
      FPSR_SUSP:
        ok = free_cmd || late_cmd;  // [R12]
    endcase
    // Gang needs select mode, a set latch and a clean byte boundary
    if (gang_cmd && !(prot_mode_r && wel_r && cmd_aligned_i))
      ok = 1'b0;  // [R1] [R5]
    go        = cmd_valid_i && ok;
    do_reset  = go && armed_r && (cmd_opcode_i == `FPSR_OP_RST);  // [R21]
    do_lock   = go && (cmd_opcode_i == `FPSR_OP_GANG_LOCK);       // [R2]
    do_unlock = go && (cmd_opcode_i == `FPSR_OP_GANG_UNLOCK);     // [R2]
    lat_load  = go && (state_r == FPSR_RUN) && !op_done_i &&
                (cmd_opcode_i == `FPSR_OP_SUSPEND);
    lat_cnt   = erase_r ? LW'(ESL_CYC) : LW'(PSL_CYC);
  end

  // Engine state; reset first, then completion, then commands
  always_comb
  begin
    state_nxt = state_r;
    if (do_reset)
      state_nxt = FPSR_IDLE;  // [R21]
    else if (op_done_i && (state_r == FPSR_RUN || state_r == FPSR_SWAIT))
      state_nxt = FPSR_IDLE;  // [R19]
    else if (state_r == FPSR_IDLE && op_start_i)
      state_nxt = FPSR_RUN;
    else if (lat_load)
      state_nxt = FPSR_SWAIT;
    else if (state_r == FPSR_SWAIT && lat_done)
      state_nxt = FPSR_SUSP;  // [R10]
    else if (go && state_r == FPSR_SUSP &&
             cmd_opcode_i == `FPSR_OP_RESUME)
      state_nxt = FPSR_RUN;  // [R16]
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      state_r <= FPSR_IDLE;
    else
      state_r <= state_nxt;
  end

  // Operation capture for region blocking and latency choice
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      erase_r   <= 1'b0;
      op_addr_r <= 32'h0000_0000;
    end
    else if (state_r == FPSR_IDLE && op_start_i)
    begin
      erase_r   <= op_erase_i;
      op_addr_r <= op_addr_i;
    end
  end

  // Write enable latch
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || do_reset)
      wel_r <= `FPSR_WEL_RESET;  // [R21]
    else if (op_done_i && state_r != FPSR_IDLE && state_r != FPSR_SUSP)
      wel_r <= 1'b0;  // [R19]
    else if (state_r == FPSR_SWAIT && lat_done)
      wel_r <= 1'b0;  // [R10]
    else if (go && state_r == FPSR_SUSP && cmd_opcode_i == `FPSR_OP_RESUME)
      wel_r <= 1'b1;  // [R15]
    else if (do_lock || do_unlock)
      wel_r <= 1'b0;
    else if (go && cmd_opcode_i == `FPSR_OP_PROT_SEL && wel_r)
      wel_r <= 1'b0;
    else if (go && cmd_opcode_i == `FPSR_OP_WRITE_ENABLE_CMD)
      wel_r <= 1'b1;
    else if (go && cmd_opcode_i == `FPSR_OP_WRITE_DISABLE_CMD)
      wel_r <= 1'b0;
  end

  // Write in progress tracks the engine, suspended time included
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || do_reset)
      wip_r <= 1'b0;  // [R21]
    else if (state_nxt == FPSR_IDLE)
      wip_r <= 1'b0;  // [R19]
    else if (state_r == FPSR_SUSP && state_nxt == FPSR_RUN)
      wip_r <= 1'b1;  // [R15]
    else if (state_r == FPSR_IDLE && op_start_i)
      wip_r <= 1'b1;
  end

  // Suspend flags, set only once the latency has elapsed
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || do_reset)
    begin
      psusp_r <= 1'b0;
      esusp_r <= 1'b0;
    end
    else if (state_r == FPSR_SWAIT && state_nxt == FPSR_SUSP)
    begin
      psusp_r <= !erase_r;  // [R8] [R10]
      esusp_r <= erase_r;   // [R8] [R10]
    end
    else if (state_r == FPSR_SUSP && state_nxt == FPSR_RUN)
    begin
      psusp_r <= 1'b0;  // [R9] [R15]
      esusp_r <= 1'b0;  // [R9] [R15]
    end
  end

  // Reset arming; any other command, no-op included, disarms
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      armed_r <= 1'b0;
    else if (cmd_valid_i)
      armed_r <= go && (cmd_opcode_i == `FPSR_OP_RST_ARM);  // [R20] [R22]
  end

  // Protect-select mode; kept across software reset as it is nonvolatile
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      prot_mode_r <= 1'b0;
    else if (go && cmd_opcode_i == `FPSR_OP_PROT_SEL && wel_r)
      prot_mode_r <= 1'b1;
  end

  // Command handshake pulses
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cmd_accept_o <= 1'b0;
      cmd_reject_o <= 1'b0;
    end
    else
    begin
      cmd_accept_o <= go;
      cmd_reject_o <= cmd_valid_i && !ok;  // [R5]
    end
  end

  // Engine controls; abort only when an operation is live
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      op_run_o   <= 1'b0;
      op_abort_o <= 1'b0;
      soft_rst_o <= 1'b0;
    end
    else
    begin
      op_run_o   <= (state_nxt == FPSR_RUN) || (state_nxt == FPSR_SWAIT);
      op_abort_o <= do_reset && (state_r != FPSR_IDLE);  // [R21]
      soft_rst_o <= do_reset;  // [R21]
    end
  end

  // Reads hitting the suspended page or sector are blocked
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      rd_block_o <= 1'b0;
    else if (state_r != FPSR_SUSP)
      rd_block_o <= 1'b0;
    else if (erase_r)
      rd_block_o <= (rd_addr_i[31:SECT_LSB] == op_addr_r[31:SECT_LSB]);  // [R7]
    else
      rd_block_o <= (rd_addr_i[31:PAGE_LSB] == op_addr_r[31:PAGE_LSB]);  // [R7]
  end

  // Registered status outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wel_o       <= `FPSR_WEL_RESET;
      wip_o       <= 1'b0;
      scur_o      <= 8'h00;
      prot_mode_o <= 1'b0;
      writable_o  <= 1'b0;
    end
    else
    begin
      wel_o       <= wel_r;
      wip_o       <= wip_r;
      scur_o      <= 8'h00;
      scur_o[`FPSR_SCUR_PSUSP_BIT] <= psusp_r;  // [R8]
      scur_o[`FPSR_SCUR_ESUSP_BIT] <= esusp_r;  // [R8]
      prot_mode_o <= prot_mode_r;
      writable_o  <= prot_wr;  // [R6]
    end
  end

  // Suspend latency timer; a reset or early finish drops it
  fpsr_latency #(
    .W (LW)
  ) u_lat (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .abort_i   (do_reset || op_done_i),
    .load_i    (lat_load),
    .count_i   (lat_cnt),
    .done_o    (lat_done)
  );

  // Dynamic protection array
  fpsr_protect #(
    .SECTORS (SECTORS),
    .SW      (SW)
  ) u_prot (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .soft_rst_i (do_reset),
    .lock_i     (do_lock),
    .unlock_i   (do_unlock),
    .solid_i    (solid_bits_i),
    .sel_i      (sector_sel_i),
    .writable_o (prot_wr),
    .dyn_o      (dyn_bits_o)
  );

endmodule
`default_nettype wire

// [fpsr_ctrl_props.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fpsr_cfg.svh"

// Port-level checks of the command controller, one clock domain
module fpsr_ctrl_props #(
  parameter int SECTORS = 16,
  parameter int SW      = 4
) (
  input wire logic               sys_clk_i,     // System clock
  input wire logic               rst_i,         // Sync reset
  input wire logic               cmd_valid_i,   // Command strobe
  input wire logic [7:0]         cmd_opcode_i,  // Opcode
  input wire logic               cmd_aligned_i, // Byte-boundary end
  input wire logic               op_start_i,    // Launch pulse
  input wire logic               op_done_i,     // Engine finished
  input wire logic [SECTORS-1:0] solid_bits_i,  // Solid bits
  input wire logic [SW-1:0]      sector_sel_i,  // Queried sector
  input wire logic               cmd_accept_o,  // Accept pulse
  input wire logic               cmd_reject_o,  // Reject pulse
  input wire logic               wel_o,         // Write enable latch
  input wire logic               wip_o,         // Busy
  input wire logic [7:0]         scur_o,        // Security byte
  input wire logic               op_run_o,      // Engine may run
  input wire logic               soft_rst_o,    // Soft reset pulse
  input wire logic               prot_mode_o,   // Protect-select mode
  input wire logic               writable_o,    // Sector writable
  input wire logic [SECTORS-1:0] dyn_bits_o     // Dynamic bits
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // Gang opcode seen this cycle
  wire logic gang = cmd_valid_i && (cmd_opcode_i == `FPSR_OP_GANG_LOCK ||
                                    cmd_opcode_i == `FPSR_OP_GANG_UNLOCK);
  wire logic arm  = cmd_valid_i && cmd_opcode_i == `FPSR_OP_RST_ARM;
  wire logic fire = cmd_valid_i && cmd_opcode_i == `FPSR_OP_RST;

  AST_ANSWER: assert property (cmd_valid_i |=> cmd_accept_o != cmd_reject_o)
    else $error("Command not answered exactly once");
  AST_QUIET: assert property (!cmd_valid_i |=> !cmd_accept_o && !cmd_reject_o)
    else $error("Answer without a command");
  // Past guards keep a just-taken protect-select out, its output lags
  AST_GANG_NOSEL: assert property (gang && !prot_mode_o && !$past(cmd_valid_i)
    && !$past(cmd_valid_i, 2) |=> cmd_reject_o && $stable(dyn_bits_o))
    else $error("Gang command acted without protect-select");
  AST_GANG_SPLIT: assert property (gang && !cmd_aligned_i && !$past(cmd_valid_i)
    |=> cmd_reject_o && $stable(dyn_bits_o))
    else $error("Unaligned gang command acted");
  AST_LOCK: assert property (cmd_valid_i && cmd_opcode_i == `FPSR_OP_GANG_LOCK
    ##1 cmd_accept_o |-> dyn_bits_o == {SECTORS{1'b1}})
    else $error("Gang lock left bits clear");
  AST_UNLOCK: assert property (cmd_valid_i && cmd_opcode_i == `FPSR_OP_GANG_UNLOCK
    ##1 cmd_accept_o |-> dyn_bits_o == {SECTORS{1'b0}})
    else $error("Gang unlock left bits set");
  AST_SUSP_ENTRY: assert property ($rose(scur_o[2]) || $rose(scur_o[3])
    |-> !wel_o && !op_run_o)
    else $error("Suspend entry with latch set or engine running");
  AST_RESUME: assert property (cmd_valid_i && cmd_opcode_i == `FPSR_OP_RESUME
    ##1 cmd_accept_o |-> op_run_o ##1 wel_o && wip_o && scur_o[3:2] == 2'b00)
    else $error("Resume did not restore latch, busy and flags");
  AST_IDLE_SUSP: assert property (cmd_valid_i && cmd_opcode_i == `FPSR_OP_SUSPEND
    && !wip_o && !op_run_o && !$past(op_start_i) && !$past(op_start_i, 2)
    |=> cmd_reject_o)
    else $error("Suspend taken with nothing running");
  AST_DONE: assert property (op_done_i && op_run_o && !cmd_valid_i
    |=> ##1 !wel_o && !wip_o)
    else $error("Finish left latch or busy set");
  AST_WRITABLE: assert property (($stable(dyn_bits_o) && $stable(solid_bits_i)
    && $stable(sector_sel_i)) [*3]
    |-> writable_o == (!dyn_bits_o[sector_sel_i] && !solid_bits_i[sector_sel_i]))
    else $error("Writable state wrong");
  AST_SOFT_RST: assert property (arm ##1 fire |-> ##[1:2] soft_rst_o)
    else $error("Armed reset not executed");
  AST_DISARM: assert property (arm ##1 (cmd_valid_i && cmd_opcode_i != `FPSR_OP_RST
    && cmd_opcode_i != `FPSR_OP_RST_ARM) ##1 fire |=> !soft_rst_o [*3])
    else $error("Disarmed reset executed");

  cover property (gang && cmd_aligned_i ##1 cmd_accept_o);
  cover property ($rose(scur_o[3]));
  cover property ($rose(soft_rst_o));
endmodule

bind fpsr_ctrl fpsr_ctrl_props #(.SECTORS(SECTORS), .SW(SW)) u_props (
  .sys_clk_i, .rst_i, .cmd_valid_i, .cmd_opcode_i, .cmd_aligned_i, .op_start_i,
  .op_done_i, .solid_bits_i, .sector_sel_i, .cmd_accept_o, .cmd_reject_o,
  .wel_o, .wip_o, .scur_o, .op_run_o, .soft_rst_o, .prot_mode_o,
  .writable_o, .dyn_bits_o
);
`default_nettype wire

// [fpsr_latency.sv]
`timescale 1ns/1ps
`default_nettype none

// Down counter: load a cycle count, pulse done when it expires
module fpsr_latency #(
  parameter int W = 16
) (
  input  wire logic         sys_clk_i,  // System clock
  input  wire logic         rst_i,      // Sync reset, active high
  input  wire logic         abort_i,    // Drop a running count
  input  wire logic         load_i,     // Start counting
  input  wire logic [W-1:0] count_i,    // Cycles to wait
  output logic              done_o      // One-cycle expiry pulse
);

  logic [W-1:0] cnt_r;   // Remaining cycles
  logic         busy_r;  // Count running

  // Counting; an abort wins so a reset never yields a late done
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || abort_i)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_o <= 1'b0;
    end
    else if (load_i)
    begin
      cnt_r  <= count_i;
      busy_r <= 1'b1;
      done_o <= 1'b0;
    end
    else if (busy_r)
    begin
      // Expiry at count one keeps the wait exactly count_i cycles
      done_o <= (cnt_r <= W'(1));
      busy_r <= (cnt_r > W'(1));
      cnt_r  <= cnt_r - W'(1);
    end
    else
    begin
      done_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [fpsr_pkg.sv]
package fpsr_pkg;

  // Operation engine states, Gray coded along run -> wait -> suspended
  typedef enum logic [1:0] {
    FPSR_IDLE = 2'b00,
    FPSR_RUN  = 2'b01,
    FPSR_SWAIT = 2'b11,
    FPSR_SUSP = 2'b10
  } fpsr_state_t;

endpackage

// [fpsr_protect.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fpsr_cfg.svh"

// Per-sector dynamic protection bits and combined writable state
module fpsr_protect #(
  parameter int SECTORS = 16,
  parameter int SW      = 4
) (
  input  wire logic               sys_clk_i,    // System clock
  input  wire logic               rst_i,        // Sync reset, active high
  input  wire logic               soft_rst_i,   // Software reset pulse
  input  wire logic               lock_i,       // Gang lock pulse
  input  wire logic               unlock_i,     // Gang unlock pulse
  input  wire logic [SECTORS-1:0] solid_i,      // Solid protect bits
  input  wire logic [SW-1:0]      sel_i,        // Sector queried
  output logic                    writable_o,   // Selected sector writable
  output logic [SECTORS-1:0]      dyn_o         // Dynamic protect bits
);

  logic [SECTORS-1:0] wr_vec;  // Writable per sector

  // One dynamic bit per sector; volatile, so protected after any reset
  for (genvar s = 0; s < SECTORS; s++)
  begin : g_sec
    always_ff @(posedge sys_clk_i)
    begin
      if (rst_i || soft_rst_i)
        dyn_o[s] <= `FPSR_DYN_RESET;
      else if (lock_i)
        dyn_o[s] <= 1'b1;  // [R2]
      else if (unlock_i)
        dyn_o[s] <= 1'b0;  // [R2]
    end
    // Writable only when both protection bits are clear
    assign wr_vec[s] = ~dyn_o[s] & ~solid_i[s];  // [R6]
  end

  assign writable_o = wr_vec[sel_i];

endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fpsr_cfg.svh"

module tb;
  logic        clk = 1'b0;       // System clock
  logic        rst = 1'b1;       // Reset
  logic        valid = 1'b0;     // Command strobe
  logic [7:0]  opcode = 8'h00;   // Opcode
  logic [31:0] addr = 32'h0;     // Command address
  logic        aligned = 1'b1;   // Byte-boundary end
  logic        op_start = 1'b0;  // Launch pulse
  logic        op_erase = 1'b0;  // Launch kind
  logic [31:0] op_addr = 32'h0;  // Launch address
  logic [31:0] rd = 32'h0;       // Read address
  logic [15:0] solid = 16'h0000; // Solid bits
  logic [3:0]  sel = 4'h0;       // Queried sector
  logic        op_done, acc, rej, write_enable_latch, write_in_progress, op_run, abort, srst, prot, rdb, wr;
  logic [7:0]  scur;             // Security byte
  logic [15:0] dyn;              // Dynamic bits
  int          error_cnt = 0, cmp_count = 0, acc_n = 0, soft_n = 0, cyc = 0, a0;
  // Status word: security byte high, flags low
  wire logic [15:0] st = {scur, 2'b00, write_enable_latch, write_in_progress, op_run, prot, rdb, wr};

  always #5 clk = ~clk;

  fpsr_ctrl #(.PSL_CYC(5), .ESL_CYC(5)) dut (
    .sys_clk_i(clk), .rst_i(rst), .cmd_valid_i(valid), .cmd_opcode_i(opcode),
    .cmd_addr_i(addr), .cmd_aligned_i(aligned), .op_start_i(op_start),
    .op_erase_i(op_erase), .op_addr_i(op_addr), .op_done_i(op_done), .rd_addr_i(rd),
    .solid_bits_i(solid), .sector_sel_i(sel), .cmd_accept_o(acc), .cmd_reject_o(rej),
    .wel_o(write_enable_latch), .wip_o(write_in_progress), .scur_o(scur), .op_run_o(op_run), .op_abort_o(abort),
    .soft_rst_o(srst), .prot_mode_o(prot), .rd_block_o(rdb), .writable_o(wr),
    .dyn_bits_o(dyn));

  fpsr_array_model #(.RUN_CYC(40)) u_array (
    .sys_clk_i(clk), .rst_i(rst), .start_i(op_start), .op_run_i(op_run),
    .op_abort_i(abort), .op_done_o(op_done));

  // Event counters and hang guard
  always @(posedge clk)
  begin
    acc_n += (acc === 1'b1);
    soft_n += (srst === 1'b1) + 16 * (abort === 1'b1);
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One command cycle, strobe left high
  task automatic cmd(input logic [7:0] op, input logic [31:0] a = 32'h0,
                     input logic al = 1'b1);
    @(posedge clk);
    valid <= 1'b1;
    opcode <= op;
    addr <= a;
    aligned <= al;
  endtask

  task automatic gap(input int n);
    @(posedge clk);
    valid <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Single command, then compare how many were accepted
  task automatic one(input logic [7:0] op, input logic [31:0] a, input int n,
                     input logic al = 1'b1);
    int b0;
    b0 = acc_n;
    cmd(op, a, al);
    gap(4);
    check(16'(acc_n - b0), 16'(n));
  endtask

  task automatic launch(input logic er, input logic [31:0] a);
    @(posedge clk);
    op_start <= 1'b1;
    op_erase <= er;
    op_addr <= a;
    @(posedge clk);
    op_start <= 1'b0;
    gap(8);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic exp);
    @(posedge clk);
    rd <= a;
    gap(1);
    check(16'(rdb), 16'(exp));
  endtask

  task automatic conclude();
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    gap(2);
    check(st, 16'h0000);
    check(dyn, 16'hFFFF);
    $display("Test reset done");
    // Gang commands: gating by mode, latch and alignment
    one(`FPSR_OP_GANG_LOCK, 32'h0, 0);
    one(`FPSR_OP_WRITE_ENABLE_CMD, 32'h0, 1);
    one(`FPSR_OP_PROT_SEL, 32'h0, 1);
    check(st, 16'h0004);
    one(`FPSR_OP_GANG_UNLOCK, 32'h0, 0);
    one(`FPSR_OP_WRITE_ENABLE_CMD, 32'h0, 1);
    one(`FPSR_OP_GANG_UNLOCK, 32'h0, 0, 1'b0);
    check(dyn, 16'hFFFF);
    one(`FPSR_OP_WRITE_ENABLE_CMD, 32'h0, 1);
    one(`FPSR_OP_GANG_UNLOCK, 32'h0, 1);
    check(dyn, 16'h0000);
    @(posedge clk);
    solid <= 16'h00F0;
    for (int s = 0; s < 16; s++)
    begin
      @(posedge clk);
      sel <= 4'(s);
      gap(2);
      check(16'(wr), 16'(!solid[s]));
    end
    one(`FPSR_OP_WRITE_ENABLE_CMD, 32'h0, 1);
    one(`FPSR_OP_GANG_LOCK, 32'h0, 1);
    check(dyn, 16'hFFFF);
    $display("Test gang done");
    // Program suspend, suspended command set, resume, finish
    one(`FPSR_OP_WRITE_ENABLE_CMD, 32'h0, 1);
    launch(1'b0, 32'h0000_1230);
    check(st & 16'hFF18, 16'h0018);
    one(`FPSR_OP_SUSPEND, 32'h0, 1);
    gap(6);
    check(st & 16'hFF2A, 16'h0400);
    rdchk(32'h0000_12FF, 1'b1);
    rdchk(32'h0000_1300, 1'b0);
    one(8'h03, 32'h0, 1);
    one(`FPSR_OP_CR2_WR, 32'h4000_0000, 0);
    one(`FPSR_OP_CR2_WR, 32'h8000_0000, 1);
    one(`FPSR_OP_CR2_WR, 32'h0000_0000, 1);
    one(`FPSR_OP_RESUME, 32'h0, 1);
    check(st & 16'hFF38, 16'h0038);
    gap(40);
    check(st & 16'hFF38, 16'h0000);
    $display("Test program suspend done");
    // Erase suspend, early commands, reset mid-operation
    one(`FPSR_OP_WRITE_ENABLE_CMD, 32'h0, 1);
    one(`FPSR_OP_GANG_UNLOCK, 32'h0, 1);
    launch(1'b1, 32'h0000_5000);
    a0 = acc_n;
    cmd(`FPSR_OP_SUSPEND);
    cmd(8'h03);
    cmd(`FPSR_OP_WRITE_DISABLE_CMD);
    gap(8);
    check(16'(acc_n - a0), 16'h0002);
    check(st & 16'hFF28, 16'h0800);
    rdchk(32'h0000_5FFF, 1'b1);
    rdchk(32'h0000_6000, 1'b0);
    a0 = soft_n;
    cmd(`FPSR_OP_RST_ARM);
    cmd(`FPSR_OP_RST);
    gap(4);
    check(16'(soft_n - a0), 16'h0011);
    check(st, 16'h0004);
    check(dyn, 16'hFFFF);
    $display("Test erase suspend and reset done");
    // Disarming, lone reset, suspend with nothing running
    a0 = soft_n;
    cmd(`FPSR_OP_RST_ARM);
    cmd(`FPSR_OP_NOP);
    cmd(`FPSR_OP_RST);
    gap(2);
    cmd(`FPSR_OP_RST_ARM);
    cmd(8'h05);
    cmd(`FPSR_OP_RST);
    gap(4);
    check(16'(soft_n - a0), 16'h0000);
    one(`FPSR_OP_SUSPEND, 32'h0, 0);
    check(st, 16'h0004);
    $display("Test disarm done");
    conclude();
  end
endmodule
`default_nettype wire
